// ---- src/lpw_pkg.sv ----
/*
 package for the low-power wake configuration register block.
 assumes a 20 mhz core clock and spi-framed 32-bit commands.
*/
package lpw_pkg;
	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int LPW_FRAME_BITS = 32;
	localparam int LPW_ADDR_MSB = 31;
	localparam int LPW_ADDR_LSB = 25;
	localparam int LPW_RW_BIT = 24;
	localparam int LPW_FAULT_BIT = 23;
	localparam int LPW_INT_BIT = 22;
	localparam int LPW_BG_CHANNELS = 8;
	localparam int LPW_GO_CHANNELS = 14;
	// ----------------------------------------
	// register addresses (7-bit)
	// ----------------------------------------
	localparam logic [6:0] LPW_ADDR_WAKE_BG = 7'h10;
	localparam logic [6:0] LPW_ADDR_WAKE_GO = 7'h11;
	localparam logic [6:0] LPW_ADDR_CMP_BG = 7'h12;
	localparam logic [6:0] LPW_ADDR_CMP_GO = 7'h13;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] LPW_RST_WAKE_BG = 8'hff;
	localparam logic [13:0] LPW_RST_WAKE_GO = 14'h3fff;
	localparam logic [7:0] LPW_RST_CMP_BG = 8'h00;
	localparam logic [13:0] LPW_RST_CMP_GO = 14'h0000;
	// ----------------------------------------
	// decoded command carrier
	// ----------------------------------------
	typedef struct packed {
		logic [6:0] addr;
		logic write;
		logic [23:0] data;
	} lpw_cmd_type;
	// channel state carrier
	typedef struct packed {
		logic [13:0] go;
		logic [7:0] bg;
	} lpw_chan_type;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic lpw_cmd_type lpw_decode(input logic [31:0] frame);
		lpw_cmd_type c;
		c.addr = frame[LPW_ADDR_MSB:LPW_ADDR_LSB];
		c.write = frame[LPW_RW_BIT];
		c.data = frame[23:0];
		return c;
	endfunction
endpackage

// ---- src/lpw_spi_shift.sv ----
/*
 spi slave shifter: 32-bit frame in, 24-bit answer out on the next frame.
 assumes sclk, cs and mosi already synchronous to core_clk, spi mode 0.
*/
`timescale 1ns/10ps
`default_nettype none
module lpw_spi_shift import lpw_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// spi pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	// frame side
	input wire logic [23:0] reply_word,
	output logic frame_done,
	output logic [31:0] frame_data
);
	logic sclk_d; // previous sclk
	logic [31:0] shift_in; // incoming bits
	logic [5:0] bit_count; // bits seen this frame
	logic [31:0] shift_out; // outgoing bits
	logic cs_d; // previous select
	wire rise = spi_sclk & ~sclk_d;
	wire fall = ~spi_sclk & sclk_d;

	// edge history
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_d <= spi_sclk;
			cs_d <= spi_cs_n;
		end
	end

	// receive path, frame taken on cs rising after 32 bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_in <= 32'h0000_0000;
			bit_count <= 6'h00;
			frame_done <= 1'b0;
			frame_data <= 32'h0000_0000;
		end else begin
			frame_done <= 1'b0;
			if (spi_cs_n) begin
				// frame end, only exact 32-bit frames count
				if (!cs_d && bit_count == 6'h20) begin
					frame_done <= 1'b1;
					frame_data <= shift_in;
				end
				bit_count <= 6'h00;
			end else if (rise) begin
				shift_in <= {shift_in[30:0], spi_mosi};
				if (bit_count != 6'h3f) begin
					bit_count <= bit_count + 6'h01;
				end
			end
		end
	end

	// transmit path, answer loaded at select fall
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_out <= 32'h0000_0000;
			spi_miso <= 1'b0;
		end else if (cs_d && !spi_cs_n) begin
			shift_out <= {reply_word, 8'h00};
			spi_miso <= reply_word[23];
		end else if (!spi_cs_n && fall) begin
			shift_out <= {shift_out[30:0], 1'b0};
			spi_miso <= shift_out[30];
		end
	end
endmodule
`default_nettype wire

// ---- src/lpw_wake_detect.sv ----
/*
 wake detector: watches channel states in low-power mode.
 assumes channel states are synchronous and lp_tick is a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module lpw_wake_detect import lpw_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic low_power_mode,
	input wire logic lp_tick,
	input wire lpw_chan_type wake_en,
	input wire lpw_chan_type cmp_only,
	input wire lpw_chan_type chan_state,
	// result
	output logic wake_event
);
	lpw_chan_type last_state; // state at previous sample
	lpw_chan_type sample_en; // channels looked at this cycle
	// comparator-only channels sample every cycle, polled ones on tick
	always_comb begin
		sample_en = cmp_only | (lp_tick ? 22'h3fffff : 22'h000000);
	end

	// change detection, only enabled channels wake
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_state <= 22'h000000;
			wake_event <= 1'b0;
		end else begin
			wake_event <= 1'b0;
			if (!low_power_mode) begin
				last_state <= chan_state;
			end else begin
				last_state <= (chan_state & sample_en) | (last_state & ~sample_en);
				wake_event <= |((chan_state ^ last_state) & sample_en & wake_en);
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/lpw_regs.sv ----
/*
 low-power wake configuration registers reached over spi.
 assumes synchronous pins, a core_clk of 20 mhz, an lp tick from outside.
*/
// Overview of operation
// - enabled battery-or-ground channel change wakes device
// - enabled ground-only channel change wakes device
// - disabled channel never wakes device
// - wake enables writable any time in normal
// - wake enables reset to all ones
// - all wake enables zero stops polling timer
// - battery-or-ground comparator-only: comparator on, no current
// - ground-only comparator-only: comparator on, no current
// - comparator-only input follows signal, wakes on change
`timescale 1ns/10ps
`default_nettype none
module lpw_regs import lpw_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// spi pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	// device status
	input wire logic low_power_mode,
	input wire logic lp_tick,
	input wire logic fault_status,
	input wire logic interrupt_flag,
	input wire logic [7:0] battery_or_ground_channel,
	input wire logic [13:0] ground_only_channel,
	// low-power controls
	output logic polling_timer_en,
	output logic [7:0] bg_polling_current_off,
	output logic [13:0] go_polling_current_off,
	output logic wake_request
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] wake_enable_battery_ground_channels; // wake mask, bg
	logic [13:0] wake_enable_ground_channels; // wake mask, ground-only
	logic [7:0] comparator_only_battery_ground_channels; // cmp-only, bg
	logic [13:0] comparator_only_ground_channels; // cmp-only, ground-only
	logic frame_done; // full frame received
	logic [31:0] frame_data; // received frame
	logic [23:0] reply_word; // next answer
	logic wake_event; // detector output
	lpw_cmd_type cmd; // decoded frame
	lpw_chan_type wake_en; // packed masks
	lpw_chan_type cmp_only; // packed cmp masks
	lpw_chan_type chan_state; // packed inputs

	assign cmd = lpw_decode(frame_data);
	assign wake_en = {wake_enable_ground_channels, wake_enable_battery_ground_channels};
	assign cmp_only = {comparator_only_ground_channels, comparator_only_battery_ground_channels};
	assign chan_state = {ground_only_channel, battery_or_ground_channel};

	// ----------------------------------------
	// spi shifter
	// ----------------------------------------
	lpw_spi_shift u_shift (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.reply_word(reply_word),
		.frame_done(frame_done),
		.frame_data(frame_data)
	);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// wake enables, written only outside low-power mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_enable_battery_ground_channels <= LPW_RST_WAKE_BG;
			wake_enable_ground_channels <= LPW_RST_WAKE_GO;
		end else if (frame_done && cmd.write && !low_power_mode) begin
			if (cmd.addr == LPW_ADDR_WAKE_BG) begin
				wake_enable_battery_ground_channels <= cmd.data[7:0];
			end
			if (cmd.addr == LPW_ADDR_WAKE_GO) begin
				wake_enable_ground_channels <= cmd.data[13:0];
			end
		end
	end

	// comparator-only masks
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			comparator_only_battery_ground_channels <= LPW_RST_CMP_BG;
			comparator_only_ground_channels <= LPW_RST_CMP_GO;
		end else if (frame_done && cmd.write && !low_power_mode) begin
			if (cmd.addr == LPW_ADDR_CMP_BG) begin
				comparator_only_battery_ground_channels <= cmd.data[7:0];
			end
			if (cmd.addr == LPW_ADDR_CMP_GO) begin
				comparator_only_ground_channels <= cmd.data[13:0];
			end
		end
	end

	// ----------------------------------------
	// reply word
	// ----------------------------------------
	// answer for next frame: status bits plus addressed contents
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_word <= 24'h000000;
		end else if (frame_done) begin
			reply_word[LPW_FAULT_BIT] <= fault_status;
			reply_word[LPW_INT_BIT] <= interrupt_flag;
			case (cmd.addr)
				LPW_ADDR_WAKE_BG: reply_word[21:0] <= {14'h0000, wake_enable_battery_ground_channels};
				LPW_ADDR_WAKE_GO: reply_word[21:0] <= {8'h00, wake_enable_ground_channels};
				LPW_ADDR_CMP_BG: reply_word[21:0] <= {14'h0000, comparator_only_battery_ground_channels};
				LPW_ADDR_CMP_GO: reply_word[21:0] <= {8'h00, comparator_only_ground_channels};
				default: reply_word[21:0] <= 22'h000000;
			endcase
		end
	end

	// ----------------------------------------
	// low-power controls
	// ----------------------------------------
	// polling timer off when no channel may wake
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			polling_timer_en <= 1'b1;
		end else begin
			polling_timer_en <= |wake_en;
		end
	end

	// polling current suppressed on comparator-only channels in lpm
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bg_polling_current_off <= 8'h00;
			go_polling_current_off <= 14'h0000;
		end else begin
			bg_polling_current_off <= low_power_mode ? comparator_only_battery_ground_channels : 8'h00;
			go_polling_current_off <= low_power_mode ? comparator_only_ground_channels : 14'h0000;
		end
	end

	// ----------------------------------------
	// wake detection
	// ----------------------------------------
	lpw_wake_detect u_wake (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.low_power_mode(low_power_mode),
		.lp_tick(lp_tick & polling_timer_en),
		.wake_en(wake_en),
		.cmp_only(cmp_only),
		.chan_state(chan_state),
		.wake_event(wake_event)
	);

	// registered wake request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= wake_event;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_timer_off;
		@(posedge core_clk) disable iff (!rst_n)
		(wake_en == 22'h000000) |=> !polling_timer_en;
	endproperty
	a_timer_off: assert property (p_timer_off) else $error("polling timer runs with no wake channel");

	property p_no_lpm_write;
		@(posedge core_clk) disable iff (!rst_n)
		low_power_mode |=> $stable(wake_en) || !$past(low_power_mode);
	endproperty
	a_no_lpm_write: assert property (p_no_lpm_write) else $error("wake mask changed in low power");

	property p_wake_bg;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_done && cmd.write && !low_power_mode && cmd.addr == LPW_ADDR_WAKE_BG)
			|=> wake_enable_battery_ground_channels == $past(frame_data[7:0]);
	endproperty
	a_wake_bg: assert property (p_wake_bg) else $error("bg wake write lost");

	property p_wake_go;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_done && cmd.write && !low_power_mode && cmd.addr == LPW_ADDR_WAKE_GO)
			|=> wake_enable_ground_channels == $past(frame_data[13:0]);
	endproperty
	a_wake_go: assert property (p_wake_go) else $error("ground-only wake write lost");

	property p_reply_status;
		@(posedge core_clk) disable iff (!rst_n)
		frame_done |=> reply_word[23] == $past(fault_status) && reply_word[22] == $past(interrupt_flag);
	endproperty
	a_reply_status: assert property (p_reply_status) else $error("reply status bits wrong");

	property p_no_wake_masked;
		@(posedge core_clk) disable iff (!rst_n)
		(wake_en == 22'h000000) [*2] |=> !wake_request;
	endproperty
	a_no_wake_masked: assert property (p_no_wake_masked) else $error("wake without enabled channel");

	property p_cmp_wake;
		@(posedge core_clk) disable iff (!rst_n)
		(low_power_mode && $past(low_power_mode) && |((chan_state ^ $past(chan_state)) & cmp_only & wake_en))
			|=> ##1 wake_request;
	endproperty
	a_cmp_wake: assert property (p_cmp_wake) else $error("comparator-only change missed");

	property p_current_off;
		@(posedge core_clk) disable iff (!rst_n)
		low_power_mode |=> bg_polling_current_off == $past(comparator_only_battery_ground_channels)
			&& go_polling_current_off == $past(comparator_only_ground_channels);
	endproperty
	a_current_off: assert property (p_current_off) else $error("polling current not suppressed");

	// polling current applied to every channel in normal mode
	property p_current_normal;
		@(posedge core_clk) disable iff (!rst_n)
		!low_power_mode |=> bg_polling_current_off == 8'h00 && go_polling_current_off == 14'h0000;
	endproperty
	a_current_normal: assert property (p_current_normal) else $error("current off outside low power");

	// polling timer runs while any channel may wake
	property p_timer_on;
		@(posedge core_clk) disable iff (!rst_n)
		(wake_en != 22'h000000) |=> polling_timer_en;
	endproperty
	a_timer_on: assert property (p_timer_on) else $error("polling timer stopped with a wake channel");

	// comparator masks frozen while in low power
	property p_cmp_frozen;
		@(posedge core_clk) disable iff (!rst_n)
		low_power_mode |=> $stable(cmp_only);
	endproperty
	a_cmp_frozen: assert property (p_cmp_frozen) else $error("comparator mask changed in low power");

	// bg comparator-only write lands one cycle after the frame
	property p_cmp_bg;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_done && cmd.write && !low_power_mode && cmd.addr == LPW_ADDR_CMP_BG)
			|=> comparator_only_battery_ground_channels == $past(frame_data[7:0]);
	endproperty
	a_cmp_bg: assert property (p_cmp_bg) else $error("bg comparator-only write lost");

	// ground-only comparator-only write lands one cycle after the frame
	property p_cmp_go;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_done && cmd.write && !low_power_mode && cmd.addr == LPW_ADDR_CMP_GO)
			|=> comparator_only_ground_channels == $past(frame_data[13:0]);
	endproperty
	a_cmp_go: assert property (p_cmp_go) else $error("ground-only comparator-only write lost");

	// reply carries the bg wake mask as it stood at frame end
	property p_reply_wake;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_done && cmd.addr == LPW_ADDR_WAKE_BG)
			|=> reply_word[21:0] == {14'h0000, $past(wake_enable_battery_ground_channels)};
	endproperty
	a_reply_wake: assert property (p_reply_wake) else $error("reply data not the wake mask");

	// unmapped address gives zero data behind the status bits
	property p_reply_unmapped;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_done && (cmd.addr < LPW_ADDR_WAKE_BG || cmd.addr > LPW_ADDR_CMP_GO))
			|=> reply_word[21:0] == 22'h000000;
	endproperty
	a_reply_unmapped: assert property (p_reply_unmapped) else $error("unmapped reply not zero");

	// no wake request raised from normal mode
	property p_no_wake_normal;
		@(posedge core_clk) disable iff (!rst_n)
		(!low_power_mode) [*2] |=> !wake_request;
	endproperty
	a_no_wake_normal: assert property (p_no_wake_normal) else $error("wake raised in normal mode");

	// enabled polled change seen on a tick wakes two cycles on
	property p_polled_wake;
		@(posedge core_clk) disable iff (!rst_n)
		(low_power_mode && lp_tick && polling_timer_en && |((chan_state ^ u_wake.last_state) & wake_en))
			|=> ##1 wake_request;
	endproperty
	a_polled_wake: assert property (p_polled_wake) else $error("polled channel change missed");

	// main scenarios reached
	c_frame: cover property (@(posedge core_clk) disable iff (!rst_n) frame_done && cmd.write);
	c_wake: cover property (@(posedge core_clk) disable iff (!rst_n) wake_request);
	c_timer_off: cover property (@(posedge core_clk) disable iff (!rst_n) !polling_timer_en);
	c_lpm_refused: cover property (@(posedge core_clk) disable iff (!rst_n) frame_done && cmd.write && low_power_mode);
	c_cmp_wake: cover property (@(posedge core_clk) disable iff (!rst_n) low_power_mode && wake_event && |(cmp_only & wake_en));
endmodule
`default_nettype wire

// ---- testbench/lpw_spi_master.sv ----
/*
 spi master model standing in for the microcontroller on the far side.
 assumes spi mode 0 and a core_clk driven by the bench; drives at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module lpw_spi_master import lpw_pkg::*; (
	// clock
	input wire logic core_clk,
	// spi pins
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso
);
	int half = 2; // sclk half period in core cycles, raised for slow frames
	// idle bus: deselected, clock low
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
	end
	// one frame msb first: address, rw, data; first 24 bits seen form the reply
	task automatic xfer(input logic [31:0] frame, input int nbits, output logic [23:0] reply);
		reply = 24'h0;
		@(negedge core_clk);
		spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_mosi = frame[31 - i];
			repeat (half) @(negedge core_clk);
			// miso sampled where sclk rises
			if (i < 24) begin
				reply[23 - i] = spi_miso;
			end
			spi_sclk = 1'b1;
			repeat (half) @(negedge core_clk);
			spi_sclk = 1'b0;
		end
		repeat (half) @(negedge core_clk);
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi; // no stale bit left on the idle line
		repeat (6) @(negedge core_clk); // gap covers write landing
	endtask
endmodule
`default_nettype wire

// ---- testbench/lpw_regs_bench.sv ----
/*
 self-checking bench for the wake configuration registers.
 assumes lpw_regs and the spi master model; stimulus at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module lpw_regs_bench import lpw_pkg::*; ;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	wire logic spi_cs_n, spi_sclk, spi_mosi, spi_miso;
	logic low_power_mode = 1'b0;
	logic lp_tick = 1'b0;
	logic fault_status = 1'b0;
	logic interrupt_flag = 1'b0;
	lpw_chan_type chan = '0; // switch states
	logic polling_timer_en, wake_request;
	logic [7:0] bg_off;
	logic [13:0] go_off;
	int mismatches = 0;
	int samples_checked = 0;
	logic [21:0] model [4]; // expected register contents
	logic [1:0] st_prev = 2'b00;
	logic [1:0] rep_st; // status due in the last reply
	logic [23:0] rep;
	// clock
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	lpw_spi_master i_mst (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso));
	lpw_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .low_power_mode(low_power_mode), .lp_tick(lp_tick),
		.fault_status(fault_status), .interrupt_flag(interrupt_flag), .battery_or_ground_channel(chan.bg),
		.ground_only_channel(chan.go), .polling_timer_en(polling_timer_en), .bg_polling_current_off(bg_off),
		.go_polling_current_off(go_off), .wake_request(wake_request));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [21:0] mask_of(input logic [6:0] a, input logic [23:0] d);
		return a[0] ? {8'h0, d[13:0]} : {14'h0, d[7:0]};
	endfunction
	function automatic logic mapped(input logic [6:0] a);
		return a >= LPW_ADDR_WAKE_BG && a <= LPW_ADDR_CMP_GO;
	endfunction
	// one frame with fresh random status bits held across it
	task automatic frame(input logic [6:0] a, input logic w, input logic [23:0] d, input int n);
		logic [1:0] st;
		st = 2'($urandom);
		@(negedge core_clk);
		{fault_status, interrupt_flag} = st;
		i_mst.xfer({a, w, d}, n, rep);
		rep_st = st_prev;
		if (n == 32) begin
			st_prev = st;
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		frame(a, 1'b1, d, 32);
		if (!low_power_mode && mapped(a)) begin
			model[a[1:0]] = mask_of(a, d);
		end
	endtask
	task automatic rd(input logic [6:0] a);
		logic [21:0] e;
		e = mapped(a) ? model[a[1:0]] : 22'h0;
		frame(a, 1'b0, 24'h0, 32);
		frame(a, 1'b0, 24'h0, 32);
		check(rep, {rep_st, e});
	endtask
	task automatic chk_out();
		logic [21:0] e;
		e = low_power_mode ? {model[2][7:0], model[3][13:0]} : 22'h0;
		check({1'b0, polling_timer_en, bg_off, go_off}, {1'b0, |(model[0] | model[1]), e});
	endtask
	// flip one switch, optionally poll, then look for a wake pulse
	task automatic poke(input int idx, input logic tick, input logic exp);
		logic seen;
		seen = 1'b0;
		@(negedge core_clk);
		chan[idx] = ~chan[idx];
		if (tick) begin
			@(negedge core_clk);
			lp_tick = 1'b1;
			@(negedge core_clk);
			lp_tick = 1'b0;
		end
		// look between edges, where the registered pulse has settled
		repeat (6) begin
			@(negedge core_clk);
			seen = seen | wake_request;
		end
		check({23'h0, seen}, {23'h0, exp});
	endtask
	task automatic set_lpm(input logic v);
		@(negedge core_clk);
		low_power_mode = v;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial begin
		#4000000;
		mismatches++;
		give_verdict();
	end
	initial begin
		logic [6:0] a;
		model = '{22'(LPW_RST_WAKE_BG), 22'(LPW_RST_WAKE_GO), 22'(LPW_RST_CMP_BG), 22'(LPW_RST_CMP_GO)};
		void'($urandom(32'h4a07));
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		// reset values, unmapped place included
		for (int i = 0; i < 5; i++) begin
			rd(7'h10 + 7'(i));
		end
		chk_out();
		// random writes in normal mode, prompt and slow master
		for (int i = 0; i < 12; i++) begin
			i_mst.half = 2 + i % 3;
			a = 7'h10 + 7'($urandom_range(4));
			wr(a, 24'($urandom));
			rd(a);
			chk_out();
		end
		i_mst.half = 2;
		// all wake bits clear stops polling timer
		wr(LPW_ADDR_WAKE_BG, 24'h0);
		wr(LPW_ADDR_WAKE_GO, 24'hffc000);
		chk_out();
		// short frame is ignored
		frame(LPW_ADDR_WAKE_BG, 1'b1, 24'hff, 31);
		rd(LPW_ADDR_WAKE_BG);
		// battery-or-ground setup: ch0 polled, ch1 comparator-only
		wr(LPW_ADDR_WAKE_BG, 24'h03);
		wr(LPW_ADDR_CMP_BG, 24'h02);
		wr(LPW_ADDR_CMP_GO, 24'h0);
		set_lpm(1'b1);
		chk_out();
		wr(LPW_ADDR_WAKE_GO, 24'h3fff);
		rd(LPW_ADDR_WAKE_GO);
		poke(0, 1'b1, 1'b1);
		poke(5, 1'b1, 1'b0);
		poke(11, 1'b1, 1'b0);
		poke(1, 1'b0, 1'b1);
		poke(1, 1'b0, 1'b1);
		// ground-only setup: ch4 polled, ch6 comparator-only
		set_lpm(1'b0);
		wr(LPW_ADDR_WAKE_GO, 24'h50);
		wr(LPW_ADDR_CMP_GO, 24'h40);
		set_lpm(1'b1);
		chk_out();
		poke(12, 1'b1, 1'b1);
		poke(14, 1'b0, 1'b1);
		poke(13, 1'b1, 1'b0);
		set_lpm(1'b0);
		chk_out();
		give_verdict();
	end
endmodule
`default_nettype wire
